// File: oledcd_pkg.sv
package oledcd_pkg;
	// Register byte offsets
	localparam logic [7:0]  OFF_BYTE      = 8'h00;
	localparam logic [7:0]  OFF_POS       = 8'h04;
	localparam logic [7:0]  OFF_CFG       = 8'h08;

	// Byte register fields
	localparam int          POS_DC        = 8;

	// Position readback fields
	localparam int          POS_COL       = 0;
	localparam int          POS_START     = 8;
	localparam int          POS_MUX       = 16;
	localparam int          POS_PEND      = 24;

	// Configuration readback fields
	localparam int          POS_CONTRAST  = 0;
	localparam int          POS_SEG       = 8;
	localparam int          POS_FORCE     = 9;
	localparam int          POS_REVERSE   = 10;
	localparam int          POS_DCDC      = 11;
	localparam int          POS_DISP      = 12;

	// Opcodes and opcode prefixes
	localparam logic [3:0]  NIB_COL_HI    = 4'h1;
	localparam logic [3:0]  NIB_COL_LO    = 4'h0;
	localparam logic [1:0]  PFX_START     = 2'h1;
	localparam logic [7:0]  OP_CONTRAST   = 8'h81;
	localparam logic [7:0]  OP_MUX        = 8'hA8;
	localparam logic [7:0]  OP_DCDC       = 8'hAD;
	localparam logic [6:0]  PFX_DCDC_ARG  = 7'h45;
	localparam logic [6:0]  PFX_SEG       = 7'h50;
	localparam logic [6:0]  PFX_FORCE     = 7'h52;
	localparam logic [6:0]  PFX_POLARITY  = 7'h53;
	localparam logic [6:0]  PFX_DISP      = 7'h57;

	// Reset values
	localparam logic [7:0]  RST_COL       = 8'h00;
	localparam logic [5:0]  RST_START     = 6'h00;
	localparam logic [7:0]  RST_CONTRAST  = 8'h80;
	localparam logic [5:0]  RST_MUX       = 6'h3F;
	localparam logic        RST_DCDC      = 1'b1;

	typedef enum logic [1:0] {
		PEND_IDLE     = 2'b00,
		PEND_CONTRAST = 2'b01,
		PEND_MUX      = 2'b11,
		PEND_DCDC     = 2'b10
	} oledcd_pend_t;
endpackage

// File: oledcd_dec_if.sv
`timescale 1ns/10ps
interface oledcd_dec_if;
	logic [7:0] cmd_byte;
	logic       col_hi;
	logic       col_lo;
	logic       start_line;
	logic       contrast_mode;
	logic       seg_remap;
	logic       force_all;
	logic       polarity;
	logic       mux_mode;
	logic       dcdc_mode;
	logic       dcdc_arg;
	logic       disp_onoff;

	modport dec (
		input  cmd_byte,
		output col_hi, col_lo, start_line, contrast_mode, seg_remap, force_all,
		output polarity, mux_mode, dcdc_mode, dcdc_arg, disp_onoff
	);
	modport user (
		output cmd_byte,
		input  col_hi, col_lo, start_line, contrast_mode, seg_remap, force_all,
		input  polarity, mux_mode, dcdc_mode, dcdc_arg, disp_onoff
	);
endinterface

// File: oledcd_decode.sv
`timescale 1ns/10ps
module oledcd_decode (
	// Opcode classification
	oledcd_dec_if.dec dif
);
	wire [7:0] b = dif.cmd_byte;

	assign dif.col_hi        = (b[7:4] == oledcd_pkg::NIB_COL_HI);
	assign dif.col_lo        = (b[7:4] == oledcd_pkg::NIB_COL_LO);
	assign dif.start_line    = (b[7:6] == oledcd_pkg::PFX_START);
	assign dif.contrast_mode = (b == oledcd_pkg::OP_CONTRAST);
	assign dif.seg_remap     = (b[7:1] == oledcd_pkg::PFX_SEG);
	assign dif.force_all     = (b[7:1] == oledcd_pkg::PFX_FORCE);
	assign dif.polarity      = (b[7:1] == oledcd_pkg::PFX_POLARITY);
	assign dif.mux_mode      = (b == oledcd_pkg::OP_MUX);
	assign dif.dcdc_mode     = (b == oledcd_pkg::OP_DCDC);
	assign dif.dcdc_arg      = (b[7:1] == oledcd_pkg::PFX_DCDC_ARG);
	assign dif.disp_onoff    = (b[7:1] == oledcd_pkg::PFX_DISP);
endmodule // oledcd_decode

// File: oledcd_top.sv
// Functional notes
// - Command-select low bytes decode into settings
// - Two nibble commands set column address
// - Column counter increments per RAM access, holding at the last column
// - Page address untouched by column increment
// - 40H-7FH load display start line
// - Rows map to ascending RAM lines
// - Start line change moves image immediately
// - 81H plus byte sets contrast
// - Byte after 81H is contrast only
// - A0H/A1H select segment order
// - A4H/A5H force all pixels on
// - Force-all-on overrides display polarity
// - A6H/A7H select display polarity
// - A8H plus byte sets multiplex ratio
// - ADH plus 8AH/8BH sets converter
// - Display and converter select power mode
// - Reset clears column, start line, remap
`timescale 1ns/10ps
module oledcd_top #(
	parameter int NUM_COLUMNS = 132,
	parameter int NUM_LINES   = 64
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Row scan from the display timing logic
	input  wire logic [5:0]  scan_row,
	input  wire logic        ram_bit,
	// Settings
	output logic      [7:0]  column_addr,
	output logic      [5:0]  start_line,
	output logic      [7:0]  contrast,
	output logic             segment_reverse_select,
	output logic             force_all_on,
	output logic             reverse_display,
	output logic      [5:0]  mux_ratio_n,
	output logic             dcdc_enable,
	output logic             display_on,
	// Power mode
	output logic             sleep_mode,
	output logic             external_supply_required,
	output logic             converter_active,
	// Scan results
	output logic      [5:0]  ram_line,
	output logic             row_active,
	output logic             pixel_on
);
	localparam logic [7:0] COL_LAST = 8'(NUM_COLUMNS - 1);

	if (NUM_COLUMNS < 2 || NUM_COLUMNS > 256) begin : g_bad_cols
		$error("NUM_COLUMNS must lie in 2..256");
	end
	if (NUM_LINES != 64) begin : g_bad_lines
		$error("NUM_LINES must be 64 for the 6-bit line fields");
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire        apb_setup  = psel & ~penable;
	wire        apb_access = psel & penable;
	wire        hit_byte   = (paddr == oledcd_pkg::OFF_BYTE);
	wire        hit_read   = hit_byte | (paddr == oledcd_pkg::OFF_POS) | (paddr == oledcd_pkg::OFF_CFG);
	wire        hit        = pwrite ? hit_byte : hit_read;
	wire        wr_en      = apb_access & pwrite & hit_byte;
	wire        is_data    = pwdata[oledcd_pkg::POS_DC];
	wire        cmd_wr     = wr_en & ~is_data;
	wire        ram_acc    = wr_en & is_data;
	wire [7:0]  cmd_byte   = pwdata[7:0];

	assign pready  = 1'b1;
	assign pslverr = apb_access & ~hit;

	////////////////////////////////////////////////////////////////////////////
	// Opcode classification

	oledcd_dec_if dif ();
	assign dif.cmd_byte = cmd_byte;

	oledcd_decode u_decode (
		.dif (dif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pending state of two-byte commands

	oledcd_pkg::oledcd_pend_t pend_r;
	oledcd_pkg::oledcd_pend_t pend_nxt;

	wire in_idle  = (pend_r == oledcd_pkg::PEND_IDLE);
	wire take     = cmd_wr & in_idle;
	wire arg_con  = cmd_wr & (pend_r == oledcd_pkg::PEND_CONTRAST);
	wire arg_mux  = cmd_wr & (pend_r == oledcd_pkg::PEND_MUX);
	wire arg_dcdc = cmd_wr & (pend_r == oledcd_pkg::PEND_DCDC);

	always_comb begin
		pend_nxt = pend_r;
		if (cmd_wr) begin
			unique case (pend_r)
				oledcd_pkg::PEND_IDLE: begin
					if (dif.contrast_mode)
						pend_nxt = oledcd_pkg::PEND_CONTRAST;
					else if (dif.mux_mode)
						pend_nxt = oledcd_pkg::PEND_MUX;
					else if (dif.dcdc_mode)
						pend_nxt = oledcd_pkg::PEND_DCDC;
				end
				oledcd_pkg::PEND_CONTRAST,
				oledcd_pkg::PEND_MUX,
				oledcd_pkg::PEND_DCDC: begin
					pend_nxt = oledcd_pkg::PEND_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_r <= oledcd_pkg::PEND_IDLE;
		else
			pend_r <= pend_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Column address counter

	logic [7:0] col_r;
	logic [7:0] col_nxt;
	wire        col_room = (col_r < COL_LAST);

	// No page state is kept here, so auto-increment never alters a page
	assign col_nxt = (take & dif.col_hi)   ? {cmd_byte[3:0], col_r[3:0]} :
	                 (take & dif.col_lo)   ? {col_r[7:4], cmd_byte[3:0]} :
	                 (ram_acc & col_room)  ? 8'(col_r + 8'h01)           :
	                 col_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			col_r <= oledcd_pkg::RST_COL;
		else
			col_r <= col_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Single-byte settings

	logic [5:0] start_r;
	logic       seg_r;
	logic       force_r;
	logic       reverse_r;
	logic       disp_r;

	// Undefined and reserved opcodes match no class and change nothing
	wire [5:0]  start_nxt   = (take & dif.start_line) ? cmd_byte[5:0] : start_r;
	wire        seg_nxt     = (take & dif.seg_remap)  ? cmd_byte[0] : seg_r;
	wire        force_nxt   = (take & dif.force_all)  ? cmd_byte[0] : force_r;
	wire        reverse_nxt = (take & dif.polarity)   ? cmd_byte[0] : reverse_r;
	wire        disp_nxt    = (take & dif.disp_onoff) ? cmd_byte[0] : disp_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_r   <= oledcd_pkg::RST_START;
			seg_r     <= 1'b0;
			force_r   <= 1'b0;
			reverse_r <= 1'b0;
			disp_r    <= 1'b0;
		end else begin
			start_r   <= start_nxt;
			seg_r     <= seg_nxt;
			force_r   <= force_nxt;
			reverse_r <= reverse_nxt;
			disp_r    <= disp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-byte settings

	logic [7:0] contrast_r;
	logic [5:0] mux_r;
	logic       dcdc_r;

	wire [7:0]  contrast_nxt = arg_con ? cmd_byte : contrast_r;
	wire [5:0]  mux_nxt      = arg_mux ? cmd_byte[5:0] : mux_r;
	wire        dcdc_nxt     = (arg_dcdc & dif.dcdc_arg) ? cmd_byte[0] : dcdc_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contrast_r <= oledcd_pkg::RST_CONTRAST;
			mux_r      <= oledcd_pkg::RST_MUX;
			dcdc_r     <= oledcd_pkg::RST_DCDC;
		end else begin
			contrast_r <= contrast_nxt;
			mux_r      <= mux_nxt;
			dcdc_r     <= dcdc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Row mapping and pixel output

	logic [5:0] line_r;
	logic       active_r;
	logic       pixel_r;

	wire [5:0]  line_nxt   = 6'(start_r + scan_row);
	wire        active_nxt = (scan_row <= mux_r);
	wire        lit        = force_r | (ram_bit ^ reverse_r);
	wire        pixel_nxt  = disp_r & active_nxt & lit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_r   <= 6'h00;
			active_r <= 1'b0;
			pixel_r  <= 1'b0;
		end else begin
			line_r   <= line_nxt;
			active_r <= active_nxt;
			pixel_r  <= pixel_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readback

	logic [31:0] prdata_r;
	logic [31:0] rd_pos;
	logic [31:0] rd_cfg;

	always_comb begin
		rd_pos = 32'h0000_0000;
		rd_pos[oledcd_pkg::POS_COL +: 8]   = col_r;
		rd_pos[oledcd_pkg::POS_START +: 6] = start_r;
		rd_pos[oledcd_pkg::POS_MUX +: 6]   = mux_r;
		rd_pos[oledcd_pkg::POS_PEND +: 2]  = pend_r;
		rd_cfg = 32'h0000_0000;
		rd_cfg[oledcd_pkg::POS_CONTRAST +: 8] = contrast_r;
		rd_cfg[oledcd_pkg::POS_SEG]     = seg_r;
		rd_cfg[oledcd_pkg::POS_FORCE]   = force_r;
		rd_cfg[oledcd_pkg::POS_REVERSE] = reverse_r;
		rd_cfg[oledcd_pkg::POS_DCDC]    = dcdc_r;
		rd_cfg[oledcd_pkg::POS_DISP]    = disp_r;
	end

	wire [31:0] rd_sel  = (paddr == oledcd_pkg::OFF_POS) ? rd_pos :
	                      (paddr == oledcd_pkg::OFF_CFG) ? rd_cfg : 32'h0000_0000;
	wire        rd_load = apb_setup & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (rd_load)
			prdata_r <= rd_sel;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata                   = prdata_r;
	assign column_addr              = col_r;
	assign start_line               = start_r;
	assign contrast                 = contrast_r;
	assign segment_reverse_select   = seg_r;
	assign force_all_on             = force_r;
	assign reverse_display          = reverse_r;
	assign mux_ratio_n              = mux_r;
	assign dcdc_enable              = dcdc_r;
	assign display_on               = disp_r;
	assign sleep_mode               = ~disp_r;
	assign external_supply_required = disp_r & ~dcdc_r;
	assign converter_active         = disp_r & dcdc_r;
	assign ram_line                 = line_r;
	assign row_active               = active_r;
	assign pixel_on                 = pixel_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_column_hi_load: assert property (
		take && pwdata[7:4] == 4'h1 |=> col_r[7:4] == $past(pwdata[3:0]) && $stable(col_r[3:0]))
		else $error("column high nibble not loaded");
	chk_column_increment: assert property (
		ram_acc && col_r < COL_LAST |=> col_r == 8'($past(col_r) + 8'h01))
		else $error("column did not increment");
	chk_column_saturate: assert property (
		ram_acc && col_r == COL_LAST |=> col_r == COL_LAST)
		else $error("column left last column");
	chk_start_line_load: assert property (
		take && pwdata[7:6] == 2'h1 |=> start_r == $past(pwdata[5:0]))
		else $error("start line not loaded");
	chk_contrast_pair: assert property (
		arg_con |=> contrast_r == $past(pwdata[7:0]) && pend_r == oledcd_pkg::PEND_IDLE)
		else $error("contrast byte not stored");
	chk_contrast_only: assert property (
		arg_con |=> $stable(force_r) && $stable(col_r) && $stable(start_r) && $stable(disp_r))
		else $error("contrast data byte decoded as command");
	chk_mux_arg: assert property (
		arg_mux |=> mux_r == $past(pwdata[5:0]) && in_idle)
		else $error("multiplex ratio not stored");
	chk_dcdc_arg: assert property (
		arg_dcdc && pwdata[7:1] == 7'h45 |=> dcdc_r == $past(pwdata[0]))
		else $error("converter setting not stored");
	chk_force_pixel: assert property (
		disp_r && force_r && scan_row <= mux_r |=> pixel_r)
		else $error("forced pixel not lit");
	chk_polarity_pixel: assert property (
		disp_r && !force_r && scan_row <= mux_r |=> pixel_r == ($past(ram_bit) ^ $past(reverse_r)))
		else $error("pixel polarity wrong");
	chk_row_mapping: assert property (
		1'b1 |=> ram_line == 6'($past(start_r) + $past(scan_row)))
		else $error("row not mapped from start line");
	chk_power_mode: assert property (
		sleep_mode |-> !converter_active && !external_supply_required)
		else $error("supply active while asleep");
	chk_reset_defaults: assert property (
		$rose(presetn) |-> col_r == 8'h00 && start_r == 6'h00 && !seg_r)
		else $error("reset defaults wrong");
	cov_contrast_pair: cover property (take && pwdata[7:0] == 8'h81 ##[1:8] arg_con);
	cov_dcdc_pair:     cover property (take && pwdata[7:0] == 8'hAD ##[1:8] arg_dcdc);
	cov_col_saturate:  cover property (ram_acc && col_r == COL_LAST);
	cov_force_pixel:   cover property (disp_r && force_r && !ram_bit && !reverse_r);
endmodule // oledcd_top

// File: oledcd_host.sv
`timescale 1ns/10ps
module oledcd_host (
	// Clock
	input  wire logic        pclk,
	// APB master side
	output logic      [7:0]  paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		paddr   = 8'h00;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		pwdata  = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One transfer; request held until pready is seen high or 16 cycles pass, ok low if it never is
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic ok);
		int n;
		ok = 1'h0;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge pclk);
			ok = (pready === 1'h1);
		end
		q   = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule // oledcd_host

// File: oledcd_bench.sv
`timescale 1ns/10ps
module oledcd_bench;
	logic        pclk = 1'h0;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  scan_row;
	logic        ram_bit;
	logic [7:0]  column_addr;
	logic [5:0]  start_line;
	logic [7:0]  contrast;
	logic        segment_reverse_select;
	logic        force_all_on;
	logic        reverse_display;
	logic [5:0]  mux_ratio_n;
	logic        dcdc_enable;
	logic        display_on;
	logic        sleep_mode;
	logic        external_supply_required;
	logic        converter_active;
	logic [5:0]  ram_line;
	logic        row_active;
	logic        pixel_on;
	logic [7:0]  ops [6];
	logic [7:0]  sl [3];
	logic [2:0]  m;
	logic [31:0] q;
	int          mismatches;
	int          n_tests;

	oledcd_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scan_row(scan_row), .ram_bit(ram_bit), .column_addr(column_addr), .start_line(start_line),
		.contrast(contrast), .segment_reverse_select(segment_reverse_select),
		.force_all_on(force_all_on), .reverse_display(reverse_display), .mux_ratio_n(mux_ratio_n),
		.dcdc_enable(dcdc_enable), .display_on(display_on), .sleep_mode(sleep_mode),
		.external_supply_required(external_supply_required), .converter_active(converter_active),
		.ram_line(ram_line), .row_active(row_active), .pixel_on(pixel_on));

	oledcd_host i_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always #12.5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic e_exp);
		logic err;
		logic ok;
		i_host.xfer(a, w, d, q, err, ok);
		if (ok !== 1'h1) begin
			mismatches++;
			close_out();
		end
		check({31'h0, err}, {31'h0, e_exp});
		#1;
	endtask

	// Host sends defined opcodes only
	task automatic cmd(input logic [8:0] b);
		bus(oledcd_pkg::OFF_BYTE, 1'h1, {23'h0, b}, 1'h0);
	endtask

	task automatic scan(input logic [5:0] r, input logic b, input logic [5:0] ln, input logic act,
		input logic pix);
		@(posedge pclk);
		scan_row <= r;
		ram_bit  <= b;
		@(posedge pclk);
		#1;
		check({24'h0, ram_line, row_active, pixel_on}, {24'h0, ln, act, pix});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn    = 1'h0;
		scan_row   = 6'h00;
		ram_bit    = 1'h0;
		mismatches = 0;
		n_tests    = 0;
		ops = '{8'hA1, 8'hA5, 8'hA7, 8'hA0, 8'hA4, 8'hA6};
		sl  = '{8'h7F, 8'h65, 8'h40};
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		#1;
		check({16'h0, column_addr, 2'h0, start_line}, 32'h0);
		check({31'h0, segment_reverse_select}, 32'h0);
		bus(oledcd_pkg::OFF_CFG, 1'h0, 32'h0, 1'h0);
		check(q, 32'h0000_0880);
		bus(oledcd_pkg::OFF_POS, 1'h0, 32'h0, 1'h0);
		check(q, 32'h003F_0000);
		$display("test reset done");

		cmd(9'h010);
		cmd(9'h000);
		repeat (4) cmd(9'h100);
		check({24'h0, column_addr}, 32'h04);
		cmd(9'h018);
		cmd(9'h002);
		cmd(9'h1AF);
		check({24'h0, column_addr}, 32'h83);
		check({31'h0, display_on}, 32'h0);
		cmd(9'h1FF);
		check({24'h0, column_addr}, 32'h83);
		$display("test column done");

		foreach (sl[k]) begin
			cmd({1'h0, sl[k]});
			check({26'h0, start_line}, {26'h0, sl[k][5:0]});
		end
		$display("test start line done");

		cmd(9'h081);
		bus(oledcd_pkg::OFF_POS, 1'h0, 32'h0, 1'h0);
		check({30'h0, q[25:24]}, 32'h1);
		cmd(9'h0A5);
		check({23'h0, force_all_on, contrast}, 32'h0A5);
		cmd(9'h081);
		cmd(9'h080);
		check({24'h0, contrast}, 32'h80);
		$display("test contrast done");

		m = 3'h0;
		foreach (ops[k]) begin
			cmd({1'h0, ops[k]});
			case (ops[k][2:1])
				2'h0: m[2] = ops[k][0];
				2'h2: m[1] = ops[k][0];
				default: m[0] = ops[k][0];
			endcase
			check({29'h0, segment_reverse_select, force_all_on, reverse_display}, {29'h0, m});
		end
		cmd(9'h0A8);
		cmd(9'h0C5);
		check({26'h0, mux_ratio_n}, 32'h05);
		$display("test modes done");

		cmd(9'h0AD);
		cmd(9'h08A);
		check({28'h0, dcdc_enable, sleep_mode, external_supply_required, converter_active}, 32'h4);
		cmd(9'h0AF);
		check({28'h0, dcdc_enable, sleep_mode, external_supply_required, converter_active}, 32'h2);
		cmd(9'h0AE);
		cmd(9'h0AD);
		cmd(9'h08B);
		cmd(9'h0AF);
		check({28'h0, dcdc_enable, sleep_mode, external_supply_required, converter_active}, 32'h9);
		$display("test power done");

		cmd(9'h045);
		scan(6'd62, 1'h1, 6'd3, 1'h0, 1'h0);
		scan(6'd5, 1'h1, 6'd10, 1'h1, 1'h1);
		cmd(9'h0A7);
		scan(6'd5, 1'h1, 6'd10, 1'h1, 1'h0);
		scan(6'd4, 1'h0, 6'd9, 1'h1, 1'h1);
		cmd(9'h0A5);
		scan(6'd4, 1'h1, 6'd9, 1'h1, 1'h1);
		cmd(9'h07F);
		cmd(9'h0AE);
		scan(6'd0, 1'h1, 6'd63, 1'h1, 1'h0);
		$display("test scan done");

		bus(oledcd_pkg::OFF_POS, 1'h1, 32'h1, 1'h1);
		bus(8'h0C, 1'h0, 32'h0, 1'h1);
		bus(oledcd_pkg::OFF_BYTE, 1'h0, 32'h0, 1'h0);
		check(q, 32'h0);
		check({26'h0, start_line}, 32'h3F);
		$display("test bus done");
		close_out();
	end
endmodule // oledcd_bench
